//--- rtl/thermo_pkg.sv
// Package for the cold-junction, raw sample and status register block.
// Assumes a 100 MHz system clock and a byte-wide register port with pointer addressing.
package thermo_pkg;

   // Register pointers.
   localparam logic [7:0] PTR_COLD = 8'h02;
   localparam logic [7:0] PTR_RAW = 8'h03;
   localparam logic [7:0] PTR_STATUS = 8'h04;
   localparam logic [7:0] PTR_DEVCFG = 8'h06;

   // Reset values.
   localparam logic [15:0] COLD_RST = 16'h0000;
   localparam logic [23:0] RAW_RST = 24'h000000;
   localparam logic [7:0] STATUS_RST = 8'h00;
   localparam logic [7:0] DEVCFG_RST = 8'h00;

   // Resolution, mode and limit field codes.
   localparam logic [1:0] ADC_18 = 2'h0;
   localparam logic [1:0] ADC_16 = 2'h1;
   localparam logic [1:0] ADC_14 = 2'h2;
   localparam logic [1:0] ADC_12 = 2'h3;
   localparam logic [1:0] MODE_NORMAL = 2'h0;
   localparam logic [1:0] MODE_SHDN = 2'h1;
   localparam logic [1:0] MODE_BURST = 2'h2;
   localparam logic [15:0] LIMIT_MASK = 16'hfffc;

   // Conversion times in milliseconds and their cycle counts.
   localparam int unsigned CYC_PER_MS = 100_000;
   localparam int unsigned CJ_FINE_MS = 250;
   localparam int unsigned CJ_COARSE_MS = 63;
   localparam int unsigned ADC18_MS = 320;
   localparam int unsigned ADC16_MS = 80;
   localparam int unsigned ADC14_MS = 20;
   localparam int unsigned ADC12_MS = 5;
   localparam int unsigned CJ_FINE_CYC = CJ_FINE_MS * CYC_PER_MS;
   localparam int unsigned CJ_COARSE_CYC = CJ_COARSE_MS * CYC_PER_MS;
   localparam int unsigned ADC18_CYC = ADC18_MS * CYC_PER_MS;
   localparam int unsigned ADC16_CYC = ADC16_MS * CYC_PER_MS;
   localparam int unsigned ADC14_CYC = ADC14_MS * CYC_PER_MS;
   localparam int unsigned ADC12_CYC = ADC12_MS * CYC_PER_MS;
   localparam int unsigned TMR_W = 26;

   // Device configuration byte, bit 7 down to bit 0.
   typedef struct packed {
      logic cj_coarse;
      logic [1:0] adc_res;
      logic [2:0] burst_code;
      logic [1:0] mode;
   } dev_cfg_t;

   // Status byte, bit 7 down to bit 0.
   typedef struct packed {
      logic burst_done;
      logic conversion_done_flag;
      logic unused;
      logic range;
      logic [3:0] alert;
   } status_t;

   typedef enum logic [2:0] {
      ST_RUN = 3'b001,
      ST_BURST = 3'b010,
      ST_HALT = 3'b100
   } run_state_t;

endpackage : thermo_pkg

//--- rtl/thermo_result_regs.sv
// Cold-junction result, raw sample and status registers of a thermocouple converter.
// Assumes the front end delivers readings and the range level on this same clock, and a
// serial slave drives the pointer, read and write strobes of the register port.
//
// Behaviour
// RULE_01: Cold-junction result is 16-bit, read-only and double-buffered against readout.
// RULE_02: Cold-junction resolution is either 0.0625 or 0.25 degrees per bit.
// RULE_03: Cold-junction result updates every 250 ms fine or 63 ms coarse.
// RULE_04: Coarse cold-junction resolution keeps the two lowest result bits at zero.
// RULE_05: Top four bits repeat the sign; twelve low bits are two's complement.
// RULE_06: Host computes upper times 16 plus lower over 16, minus 4096 if negative.
// RULE_07: An 18-bit converter sample lands in the raw sample register.
// RULE_08: Raw sample register is 24 bits, read-only, sign extended above the data.
// RULE_09: Sample times are 320, 80, 20 and 5 ms for 18, 16, 14, 12 bits.
// RULE_10: Reduced resolution zeroes two, four or six lowest raw bits.
// RULE_11: Burst-complete flag, status bit 7, sets after a burst; software clears it.
// RULE_12: Update flag, status bit 6, sets per conversion; software clears it.
// RULE_13: Status bit 4 shows the input or hot result is out of range.
// RULE_14: While out of range, conversion is skipped and results hold their values; the code holds the cold result but still updates the raw sample.
// RULE_15: Status bits 3 to 0 show selected temperature above each alert limit.
// RULE_16: Configuration bit 7 picks cold-junction resolution from the next cycle.
// RULE_17: Configuration bits 6 to 5 pick 18, 16, 14 or 12-bit sampling.
// RULE_18: Burst mode takes 1 to 128 samples, then shuts down.
// RULE_19: A multi-byte read returns bytes from one snapshot.
`timescale 1ns/1ps
module thermo_result_regs #(
   parameter int unsigned CJ_FINE_CYC = thermo_pkg::CJ_FINE_CYC,
   parameter int unsigned CJ_COARSE_CYC = thermo_pkg::CJ_COARSE_CYC,
   parameter int unsigned ADC18_CYC = thermo_pkg::ADC18_CYC,
   parameter int unsigned ADC16_CYC = thermo_pkg::ADC16_CYC,
   parameter int unsigned ADC14_CYC = thermo_pkg::ADC14_CYC,
   parameter int unsigned ADC12_CYC = thermo_pkg::ADC12_CYC
) (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic [11:0] cj_sample,
   input wire logic [17:0] adc_sample,
   input wire logic range_fault,
   input wire logic [15:0] hot_junction_result,
   input wire logic [3:0][15:0] alert_limits,
   input wire logic [3:0] alert_use_cold,
   input wire logic [7:0] reg_ptr,
   input wire logic rd_start,
   input wire logic rd_next,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   output logic shutdown_active
);

   localparam int TW = thermo_pkg::TMR_W;

   // Sample period for an ADC resolution code.
   function automatic logic [TW-1:0] adc_period(input logic [1:0] res);
      case (res)
         thermo_pkg::ADC_18: adc_period = TW'(ADC18_CYC - 1);
         thermo_pkg::ADC_16: adc_period = TW'(ADC16_CYC - 1);
         thermo_pkg::ADC_14: adc_period = TW'(ADC14_CYC - 1);
         default: adc_period = TW'(ADC12_CYC - 1);
      endcase
   endfunction : adc_period

   // Sign extends an 18-bit sample and clears the bits below the resolution.
   function automatic logic [23:0] raw_format(input logic [17:0] s, input logic [1:0] res);
      logic [23:0] v;
      v = {{6{s[17]}}, s};
      case (res)
         thermo_pkg::ADC_16: v[1:0] = 2'h0;
         thermo_pkg::ADC_14: v[3:0] = 4'h0;
         thermo_pkg::ADC_12: v[5:0] = 6'h00;
         default: v = v;
      endcase
      raw_format = v;
   endfunction : raw_format

   thermo_pkg::run_state_t state_r, state_nxt;
   thermo_pkg::dev_cfg_t cfg_r, cfg_nxt;
   thermo_pkg::status_t sts_r, sts_nxt;
   logic [TW-1:0] cj_cnt_r, cj_cnt_nxt, adc_cnt_r, adc_cnt_nxt;
   logic cj_act_r, cj_act_nxt;
   logic [1:0] adc_act_r, adc_act_nxt;
   logic [7:0] burst_cnt_r, burst_cnt_nxt;
   logic [15:0] cj_r, cj_nxt;
   logic [23:0] raw_r, raw_nxt;
   logic [23:0] snap_r, snap_nxt;
   logic [7:0] rd_data_r, rd_data_nxt;
   logic cj_tick, adc_tick, burst_last;
   logic [15:0] cj_new;

   assign cj_tick = (cj_cnt_r == '0) && (state_r != thermo_pkg::ST_HALT);
   assign adc_tick = (adc_cnt_r == '0) && (state_r != thermo_pkg::ST_HALT);
   assign burst_last = burst_cnt_r == ((8'h01 << cfg_r.burst_code) - 8'h01); // RULE_18
   assign cj_new = {{4{cj_sample[11]}}, cj_sample[11:2], cj_act_r ? 2'h0 : cj_sample[1:0]}; // RULE_04 RULE_05

   // Measurement timing, mode sequencing, results and status. A resolution change is
   // picked up only when a period reloads, so it never cuts a running conversion short; shutdown zeroes the counters and does.
   always_comb begin
      state_nxt = state_r;
      cfg_nxt = cfg_r;
      cj_cnt_nxt = cj_cnt_r - 1'b1;
      adc_cnt_nxt = adc_cnt_r - 1'b1;
      cj_act_nxt = cj_act_r;
      adc_act_nxt = adc_act_r;
      burst_cnt_nxt = burst_cnt_r;
      cj_nxt = cj_r;
      raw_nxt = raw_r;
      sts_nxt = sts_r;
      if (cj_tick) begin
         cj_act_nxt = cfg_r.cj_coarse; // RULE_16 RULE_02
         cj_cnt_nxt = cfg_r.cj_coarse ? TW'(CJ_COARSE_CYC - 1) : TW'(CJ_FINE_CYC - 1); // RULE_03
         if (!range_fault) begin
            cj_nxt = cj_new; // RULE_01 RULE_14
         end
      end
      if (adc_tick) begin
         adc_act_nxt = cfg_r.adc_res; // RULE_17
         adc_cnt_nxt = adc_period(cfg_r.adc_res); // RULE_09
         raw_nxt = raw_format(adc_sample, adc_act_r); // RULE_07 RULE_08 RULE_10
         burst_cnt_nxt = burst_cnt_r + 8'h01;
      end
      if (state_r == thermo_pkg::ST_HALT) begin
         cj_cnt_nxt = '0;
         adc_cnt_nxt = '0;
      end
      // Software clears the event flags by writing zero; a same-cycle event wins.
      if (wr_en && reg_ptr == thermo_pkg::PTR_STATUS) begin
         sts_nxt.burst_done = sts_r.burst_done & wr_data[7];
         sts_nxt.conversion_done_flag = sts_r.conversion_done_flag & wr_data[6];
      end
      if (adc_tick && !range_fault) begin
         sts_nxt.conversion_done_flag = 1'b1; // RULE_12
      end
      case (state_r)
         thermo_pkg::ST_BURST: begin
            if (adc_tick && burst_last) begin
               state_nxt = thermo_pkg::ST_HALT; // RULE_18
               sts_nxt.burst_done = 1'b1; // RULE_11
            end
         end
         thermo_pkg::ST_RUN, thermo_pkg::ST_HALT: begin
            state_nxt = state_r;
         end
         default: state_nxt = thermo_pkg::ST_HALT;
      endcase
      // A configuration write restarts sequencing; code 11 leaves the mode alone.
      if (wr_en && reg_ptr == thermo_pkg::PTR_DEVCFG) begin
         cfg_nxt = wr_data;
         burst_cnt_nxt = 8'h00;
         case (wr_data[1:0])
            thermo_pkg::MODE_NORMAL: state_nxt = thermo_pkg::ST_RUN;
            thermo_pkg::MODE_SHDN: state_nxt = thermo_pkg::ST_HALT;
            thermo_pkg::MODE_BURST: state_nxt = thermo_pkg::ST_BURST; // RULE_18
            default: state_nxt = state_r;
         endcase
      end
      sts_nxt.unused = 1'b0;
      sts_nxt.range = range_fault; // RULE_13
      for (int i = 0; i < 4; i++) begin
         sts_nxt.alert[i] = $signed(alert_use_cold[i] ? cj_r : hot_junction_result)
            > $signed(alert_limits[i] & thermo_pkg::LIMIT_MASK); // RULE_15
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= thermo_pkg::ST_RUN;
         cfg_r <= thermo_pkg::DEVCFG_RST;
         cj_cnt_r <= '0;
         adc_cnt_r <= '0;
         cj_act_r <= 1'b0;
         adc_act_r <= thermo_pkg::ADC_18;
         burst_cnt_r <= 8'h00;
         cj_r <= thermo_pkg::COLD_RST;
         raw_r <= thermo_pkg::RAW_RST;
         sts_r <= thermo_pkg::STATUS_RST;
      end else begin
         state_r <= state_nxt;
         cfg_r <= cfg_nxt;
         cj_cnt_r <= cj_cnt_nxt;
         adc_cnt_r <= adc_cnt_nxt;
         cj_act_r <= cj_act_nxt;
         adc_act_r <= adc_act_nxt;
         burst_cnt_r <= burst_cnt_nxt;
         cj_r <= cj_nxt;
         raw_r <= raw_nxt;
         sts_r <= sts_nxt;
      end
   end

   // Read port. The snapshot is the second buffer: conversions may overwrite the live
   // registers mid-read without tearing the bytes already on their way out.
   always_comb begin
      snap_nxt = snap_r;
      rd_data_nxt = rd_data_r;
      if (rd_start) begin
         case (reg_ptr)
            thermo_pkg::PTR_COLD: snap_nxt = {cj_r, 8'h00}; // RULE_19 RULE_01
            thermo_pkg::PTR_RAW: snap_nxt = raw_r; // RULE_19
            thermo_pkg::PTR_STATUS: snap_nxt = {sts_r, 16'h0000};
            thermo_pkg::PTR_DEVCFG: snap_nxt = {cfg_r, 16'h0000};
            default: snap_nxt = 24'h000000;
         endcase
         rd_data_nxt = snap_nxt[23:16];
         snap_nxt = {snap_nxt[15:0], 8'h00};
      end else if (rd_next) begin
         rd_data_nxt = snap_r[23:16];
         snap_nxt = {snap_r[15:0], 8'h00};
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         snap_r <= 24'h000000;
         rd_data_r <= 8'h00;
      end else begin
         snap_r <= snap_nxt;
         rd_data_r <= rd_data_nxt;
      end
   end

   assign rd_data = rd_data_r;
   assign shutdown_active = state_r[2];

   // Checks on the design's own behaviour.
   sequence s_burst_end;
      (state_r == thermo_pkg::ST_BURST) && adc_tick && burst_last && !wr_en;
   endsequence
   sequence s_halted;
      (state_r == thermo_pkg::ST_HALT) && sts_r.burst_done;
   endsequence

   property p_cj_only_on_tick;
      @(posedge clk_sys) disable iff (!arst_n) $changed(cj_r) |-> $past(cj_tick);
   endproperty
   a_cj_only_on_tick: assert property (p_cj_only_on_tick) else $error("cold result moved"); // RULE_01

   property p_cj_rate;
      @(posedge clk_sys) disable iff (!arst_n) cj_tick |=> !cj_tick [*8];
   endproperty
   a_cj_rate: assert property (p_cj_rate) else $error("cold period too short"); // RULE_03

   property p_cj_coarse;
      @(posedge clk_sys) disable iff (!arst_n)
         cj_tick && !range_fault && cj_act_r |=> cj_r[1:0] == 2'h0;
   endproperty
   a_cj_coarse: assert property (p_cj_coarse) else $error("coarse lsbs set"); // RULE_04

   property p_cj_sign;
      @(posedge clk_sys) disable iff (!arst_n) cj_r[15:12] == {4{cj_r[11]}};
   endproperty
   a_cj_sign: assert property (p_cj_sign) else $error("cold sign bits differ"); // RULE_05

   property p_raw_fmt;
      @(posedge clk_sys) disable iff (!arst_n)
         adc_tick && adc_act_r == thermo_pkg::ADC_12 |=> raw_r[5:0] == 6'h00
            && raw_r[23:18] == {6{raw_r[17]}};
   endproperty
   a_raw_fmt: assert property (p_raw_fmt) else $error("raw format wrong"); // RULE_10

   property p_range_hold;
      @(posedge clk_sys) disable iff (!arst_n) range_fault |=> $stable(cj_r) && sts_r.range;
   endproperty
   a_range_hold: assert property (p_range_hold) else $error("range hold broken"); // RULE_14

   property p_update_flag;
      @(posedge clk_sys) disable iff (!arst_n)
         adc_tick && !range_fault |=> sts_r.conversion_done_flag;
   endproperty
   a_update_flag: assert property (p_update_flag) else $error("update flag lost"); // RULE_12

   property p_burst_end;
      @(posedge clk_sys) disable iff (!arst_n) s_burst_end |=> s_halted ##1 shutdown_active;
   endproperty
   a_burst_end: assert property (p_burst_end) else $error("burst did not stop"); // RULE_11

   property p_read_snap;
      @(posedge clk_sys) disable iff (!arst_n)
         rd_start && reg_ptr == thermo_pkg::PTR_RAW ##1 rd_next && !rd_start
            |=> rd_data == $past(raw_r[15:8], 2);
   endproperty
   a_read_snap: assert property (p_read_snap) else $error("read bytes torn"); // RULE_19

   // Reload lengths and status bits, checked one edge after their cause.
   property p_range_flag;
      @(posedge clk_sys) disable iff (!arst_n) 1'b1 |=> sts_r.range == $past(range_fault);
   endproperty
   a_range_flag: assert property (p_range_flag) else $error("range flag wrong"); // RULE_13

   property p_flag_clear;
      @(posedge clk_sys) disable iff (!arst_n)
         wr_en && reg_ptr == thermo_pkg::PTR_STATUS && !wr_data[6] && !adc_tick
            |=> !sts_r.conversion_done_flag;
   endproperty
   a_flag_clear: assert property (p_flag_clear) else $error("update flag not cleared"); // RULE_12

   property p_cj_reload;
      @(posedge clk_sys) disable iff (!arst_n)
         cj_tick && cfg_r.cj_coarse |=> cj_cnt_r == TW'(CJ_COARSE_CYC - 1);
   endproperty
   a_cj_reload: assert property (p_cj_reload) else $error("coarse period wrong"); // RULE_03

   property p_adc12_reload;
      @(posedge clk_sys) disable iff (!arst_n)
         adc_tick && cfg_r.adc_res == thermo_pkg::ADC_12 |=> adc_cnt_r == TW'(ADC12_CYC - 1);
   endproperty
   a_adc12_reload: assert property (p_adc12_reload) else $error("12-bit period wrong"); // RULE_09

   property p_adc18_reload;
      @(posedge clk_sys) disable iff (!arst_n)
         adc_tick && cfg_r.adc_res == thermo_pkg::ADC_18 |=> adc_cnt_r == TW'(ADC18_CYC - 1);
   endproperty
   a_adc18_reload: assert property (p_adc18_reload) else $error("18-bit period wrong"); // RULE_17

endmodule : thermo_result_regs

//--- test/host_model.sv
// Host model of the register port: byte writes and byte reads with expected-byte notes.
// Assumes the bench compares rd_data one cycle after each read strobe, oldest note first.
`timescale 1ns/1ps
module host_model (
   input wire logic clk_sys,
   output logic [7:0] reg_ptr,
   output logic rd_start,
   output logic rd_next,
   output logic wr_en,
   output logic [7:0] wr_data
);
   logic [7:0] exp_q[$];

   // Idle port at time zero so that no strobe is seen before reset ends.
   initial begin
      reg_ptr = 8'h00;
      rd_start = 1'b0;
      rd_next = 1'b0;
      wr_en = 1'b0;
      wr_data = 8'h00;
   end

   // One write strobe held over one edge; an idle cycle follows so strobes never merge.
   task automatic wr(input logic [7:0] p, input logic [7:0] d);
      reg_ptr = p;
      wr_data = d;
      wr_en = 1'b1;
      @(posedge clk_sys);
      #1;
      wr_en = 1'b0;
      @(posedge clk_sys);
      #1;
   endtask : wr

   // Reads n bytes back to back, most significant first, noting each expected byte.
   task automatic rd(input logic [7:0] p, input int n, input logic [23:0] v);
      logic [23:0] s;
      s = v << (8 * (3 - n));
      reg_ptr = p;
      for (int i = 0; i < n; i++) begin
         rd_start = (i == 0);
         rd_next = (i != 0);
         exp_q.push_back(s[23:16]);
         s = s << 8;
         @(posedge clk_sys);
         #1;
      end
      rd_start = 1'b0;
      rd_next = 1'b0;
      @(posedge clk_sys);
      #1;
   endtask : rd
endmodule : host_model

//--- test/tb.sv
// Self-checking bench for the cold-junction, raw sample and status register block.
// Assumes shortened conversion periods; the front end is driven directly by the bench.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin err_total++; \
   $display("[FAIL] %0t got %h expected %h", $time, (a), (b)); end end
module tb;
   localparam logic [7:0] p_cold = thermo_pkg::PTR_COLD;
   localparam logic [7:0] p_raw = thermo_pkg::PTR_RAW;
   localparam logic [7:0] p_stat = thermo_pkg::PTR_STATUS;
   localparam logic [7:0] p_cfg = thermo_pkg::PTR_DEVCFG;
   logic clk_sys, arst_n, range_fault, rd_start, rd_next, wr_en, shutdown_active;
   logic [11:0] cj_sample;
   logic [17:0] adc_sample;
   logic [15:0] hot_junction_result, rnd, cold_e, rd_word;
   logic [3:0][15:0] alert_limits;
   logic [3:0] alert_use_cold;
   logic [7:0] reg_ptr, wr_data, rd_data, exp_b;
   logic [23:0] raw_e;
   int err_total, checks, n;

   // Shortened periods; the 18-bit one keeps its full length and set_cfg cuts it short.
   thermo_result_regs #(.CJ_FINE_CYC(40), .CJ_COARSE_CYC(20),
      .ADC16_CYC(32), .ADC14_CYC(16), .ADC12_CYC(12)) dut (.clk_sys(clk_sys),
      .arst_n(arst_n), .cj_sample(cj_sample), .adc_sample(adc_sample),
      .range_fault(range_fault), .hot_junction_result(hot_junction_result),
      .alert_limits(alert_limits), .alert_use_cold(alert_use_cold), .reg_ptr(reg_ptr),
      .rd_start(rd_start), .rd_next(rd_next), .wr_en(wr_en), .wr_data(wr_data),
      .rd_data(rd_data), .shutdown_active(shutdown_active));
   host_model host (.clk_sys(clk_sys), .reg_ptr(reg_ptr), .rd_start(rd_start),
      .rd_next(rd_next), .wr_en(wr_en), .wr_data(wr_data));

   // Free-running 100 MHz clock.
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // Each read strobe yields one byte a cycle later; compare it with the oldest note.
   always @(posedge clk_sys) begin
      if (rd_start === 1'b1 || rd_next === 1'b1) begin
         #2;
         exp_b = host.exp_q.pop_front();
         `CHK(rd_data, exp_b)
         rd_word = {rd_word[7:0], rd_data};
      end
   end

   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr

   // Alerts compare signed values; the limit's two low bits do not take part.
   function automatic logic [3:0] alerts_e(input logic [15:0] c);
      logic [3:0] a;
      for (int i = 0; i < 4; i++) begin
         a[i] = $signed(alert_use_cold[i] ? c : hot_junction_result) >
            $signed(alert_limits[i] & 16'hfffc);
      end
      return a;
   endfunction : alerts_e

   // Host conversion scaled by 16: upper times 16 plus lower over 16, less 4096 when
   // negative, so that no fraction is lost.
   function automatic int host_temp(input logic [15:0] w);
      return int'(w[15:8]) * 256 + int'(w[7:0]) - (w[15] ? 65536 : 0);
   endfunction : host_temp

   // Each setting passes through shutdown twice: the first restart latches the new
   // resolutions, the second captures with them, so no full 18-bit period is waited for.
   // Eight halted cycles keep a restart capture clear of the previous cold capture.
   task automatic set_cfg(input logic [7:0] c);
      repeat (2) begin
         host.wr(p_cfg, {c[7:2], thermo_pkg::MODE_SHDN});
         repeat (8) @(posedge clk_sys);
         #1;
         host.wr(p_cfg, c);
      end
   endtask : set_cfg

   task automatic end_sim();
      `CHK(host.exp_q.size(), 0)
      $display("checks %0d errors %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim

   // Main sequence: every resolution pair, range fault hold, status clears, then a burst.
   initial begin
      rnd = 16'h27d5;
      err_total = 0;
      checks = 0;
      arst_n = 1'b0;
      cj_sample = 12'h000;
      adc_sample = 18'h00000;
      range_fault = 1'b0;
      hot_junction_result = 16'h0000;
      alert_limits = '0;
      alert_use_cold = 4'h0;
      repeat (10) @(posedge clk_sys);
      #1;
      arst_n = 1'b1;
      host.rd(p_cfg, 1, {16'h0000, thermo_pkg::DEVCFG_RST});
      host.rd(8'h05, 1, 24'h000000);
      for (int k = 0; k < 8; k++) begin
         rnd = lfsr(rnd);
         cj_sample = rnd[11:0];
         rnd = lfsr(rnd);
         adc_sample = {rnd[1:0], rnd};
         rnd = lfsr(rnd);
         hot_junction_result = rnd;
         alert_use_cold = rnd[7:4];
         for (int i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            alert_limits[i] = rnd;
         end
         set_cfg({k[2], k[1:0], 3'h0, thermo_pkg::MODE_NORMAL});
         repeat (140) @(posedge clk_sys);
         #1;
         cold_e = {{4{cj_sample[11]}}, cj_sample} & (k[2] ? 16'hfffc : 16'hffff);
         raw_e = {{6{adc_sample[17]}}, adc_sample} & ~((24'h1 << (2 * k[1:0])) - 24'h1);
         host.rd(p_cold, 2, {8'h00, cold_e});
         `CHK(host_temp(rd_word), int'($signed(cold_e)))
         host.rd(p_raw, 3, raw_e);
         host.rd(p_stat, 1, {16'h0000, 4'h4, alerts_e(cold_e)});
      end
      range_fault = 1'b1;
      cj_sample = ~cj_sample;
      rnd = lfsr(rnd);
      adc_sample = {rnd[1:0], rnd};
      repeat (140) @(posedge clk_sys);
      #1;
      host.wr(p_stat, 8'h00);
      host.rd(p_cold, 2, {8'h00, cold_e});
      host.rd(p_raw, 3, {{6{adc_sample[17]}}, adc_sample} & 24'hffffc0);
      host.rd(p_stat, 1, {16'h0000, 4'h1, alerts_e(cold_e)});
      range_fault = 1'b0;
      repeat (140) @(posedge clk_sys);
      #1;
      cold_e = {{4{cj_sample[11]}}, cj_sample} & 16'hfffc;
      host.rd(p_cold, 2, {8'h00, cold_e});
      host.rd(p_stat, 1, {16'h0000, 4'h4, alerts_e(cold_e)});
      host.wr(p_cfg, {1'b1, thermo_pkg::ADC_12, 3'h1, thermo_pkg::MODE_BURST});
      for (n = 0; n < 500 && shutdown_active !== 1'b1; n++) @(posedge clk_sys);
      #1;
      `CHK(shutdown_active, 1'b1)
      host.rd(p_stat, 1, {16'h0000, 4'hc, alerts_e(cold_e)});
      host.wr(p_stat, 8'h00);
      host.rd(p_stat, 1, {16'h0000, 4'h0, alerts_e(cold_e)});
      end_sim();
   end
endmodule : tb
